// ===== common/wut_pkg.sv
package wut_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [31:0] ADDR_RELOAD_VALUE  = 32'hFFFF0340;   // Load value, RW
	localparam logic [31:0] ADDR_CURRENT_COUNT = 32'hFFFF0344;   // Live counter, RO
	localparam logic [31:0] ADDR_TIMER_CONFIG  = 32'hFFFF0348;   // Configuration, RW
	localparam logic [31:0] ADDR_RELOAD_CLEAR  = 32'hFFFF034C;   // Reload and clear, WO
	localparam logic [31:0] ADDR_IRQ_STATUS    = 32'hFFFF0350;   // Sticky events, W1C
	localparam logic [31:0] ADDR_IRQ_ENABLE    = 32'hFFFF0354;   // Interrupt enable mask
	localparam logic [31:0] ADDR_CAPTURE       = 32'hFFFF0358;   // Captured count, RO

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [31:0] RST_RELOAD_VALUE  = 32'h00000000;
	localparam logic [31:0] RST_CURRENT_COUNT = 32'h00000000;
	localparam logic [31:0] RST_TIMER_CONFIG  = 32'h00000000;
	localparam logic [31:0] RST_IRQ_STATUS    = 32'h00000000;
	localparam logic [31:0] RST_IRQ_ENABLE    = 32'h00000000;
	localparam logic [31:0] RST_CAPTURE       = 32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// Configuration field layout
	localparam int              CFG_SRC_LSB  = 9;               // Clock source [10:9]
	localparam int              CFG_UP_BIT   = 8;               // Count direction
	localparam int              CFG_EN_BIT   = 7;               // Timer enable
	localparam int              CFG_PER_BIT  = 6;               // Periodic mode
	localparam int              CFG_FMT_LSB  = 4;               // Format [5:4]
	localparam int              CFG_PSC_LSB  = 0;               // Prescaler [3:0]
	localparam logic [31:0]     CFG_WRITABLE = 32'h000007FF;    // Bits above 10 reserved

	// Interrupt status/enable layout
	localparam int              IRQ_TIMER_BIT = 4;              // Timer overflow event
	localparam logic [31:0]     IRQ_WRITABLE  = 32'h00000010;

	////////////////////////////////////////////////////////////////////////////
	// Clock sources and count formats
	typedef enum logic [1:0] {SRC_OSC, SRC_CORE, SRC_XTAL, SRC_PLL} wut_src_e;
	typedef enum logic [1:0] {FMT_BINARY, FMT_RESERVED, FMT_HMS23, FMT_HMS255} wut_fmt_e;

	// Prescaler codes and their terminal counts
	localparam logic [3:0]  PSC_DIV1      = 4'h0;
	localparam logic [3:0]  PSC_DIV16     = 4'h4;
	localparam logic [3:0]  PSC_DIV256    = 4'h8;
	localparam logic [3:0]  PSC_DIV32768  = 4'hF;
	localparam logic [14:0] PSC_TC_1      = 15'h0000;
	localparam logic [14:0] PSC_TC_16     = 15'h000F;
	localparam logic [14:0] PSC_TC_256    = 15'h00FF;
	localparam logic [14:0] PSC_TC_32768  = 15'h7FFF;

	// Time format field limits
	localparam logic [7:0]  HUND_MAX      = 8'h63;              // 99
	localparam logic [7:0]  MINSEC_MAX    = 8'h3B;              // 59
	localparam logic [7:0]  HOURS_MAX_23  = 8'h17;              // 23
	localparam logic [7:0]  HOURS_MAX_255 = 8'hFF;              // 255

	// AXI responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Bus carriers
	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} wut_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} wut_axi_rsp_s;

	// Pin synchroniser state
	typedef struct packed {
		logic meta;
		logic stable;
		logic last;
	} wut_sync_s;

	// Whole state of the timer
	typedef struct packed {
		wut_axi_rsp_s rsp;
		logic [31:0]  aw_addr;
		logic         aw_got;
		logic [31:0]  w_data;
		logic [3:0]   w_strb;
		logic         w_got;
		logic [31:0]  reload;
		logic [31:0]  count;
		logic [31:0]  config_r;
		logic [31:0]  capture;
		logic [31:0]  status;
		logic [31:0]  enable;
		logic [14:0]  psc_cnt;
		logic         irq;
	} wut_state_s;

	localparam wut_axi_rsp_s RSP_RST = '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
		arready: 1'b1, rvalid: 1'b0, rdata: 32'h00000000, rresp: RESP_OKAY};

	localparam wut_state_s STATE_RST = '{rsp: RSP_RST, aw_addr: 32'h00000000, aw_got: 1'b0,
		w_data: 32'h00000000, w_strb: 4'h0, w_got: 1'b0, reload: RST_RELOAD_VALUE,
		count: RST_CURRENT_COUNT, config_r: RST_TIMER_CONFIG, capture: RST_CAPTURE,
		status: RST_IRQ_STATUS, enable: RST_IRQ_ENABLE, psc_cnt: 15'h0000, irq: 1'b0};

endpackage

// ===== src/wut_edge_sync.sv
`timescale 1ns/1ps
// Brings a free-running source clock pin into sys_clk and marks its rising edges
module wut_edge_sync (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	// Asynchronous source pin
	input  wire logic pin_i,
	// One-cycle pulse per rising edge of the pin
	output logic      rise_o
);
	import wut_pkg::*;

	wut_sync_s s_reg;      // Registered state
	wut_sync_s s_next;     // Next state

	////////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser, then a history bit for edge detection
	always_comb begin
		s_next        = s_reg;
		s_next.meta   = pin_i;
		s_next.stable = s_reg.meta;
		s_next.last   = s_reg.stable;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= '{meta: 1'b0, stable: 1'b0, last: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	// Only the settled stages are compared; meta stays private
	assign rise_o = s_reg.stable & ~s_reg.last;

endmodule // wut_edge_sync

// ===== src/wut_wakeup_counter.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module wut_wakeup_counter (
	// Clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_n_i,
	// AXI4-Lite register port
	input  wire wut_pkg::wut_axi_req_s axi_req_i,
	output wut_pkg::wut_axi_rsp_s      axi_rsp_o,
	// Source clock pins
	input  wire logic                  osc32k_i,
	input  wire logic                  xtal32k_i,
	input  wire logic                  undivided_pll_clock_i,
	// Interrupt
	output logic                       irq_o
);
	import wut_pkg::*;

	wut_state_s s_reg;        // Registered state
	wut_state_s s_next;       // Next state
	logic       osc_rise;     // Internal oscillator edge
	logic       xtal_rise;    // Watch crystal edge
	logic       pll_rise;     // PLL clock edge

	////////////////////////////////////////////////////////////////////////////
	// Source pin synchronisers
	// The PLL pin is sampled like the others, so it only counts correctly
	// while it runs below half of sys_clk; faster rates alias.
	wut_edge_sync u_sync_osc (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.pin_i     (osc32k_i),
		.rise_o    (osc_rise)
	);

	wut_edge_sync u_sync_xtal (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.pin_i     (xtal32k_i),
		.rise_o    (xtal_rise)
	);

	wut_edge_sync u_sync_pll (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.pin_i     (undivided_pll_clock_i),
		.rise_o    (pll_rise)
	);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Terminal count of the prescaler; reserved codes divide by 1
	function automatic logic [14:0] psc_limit(input logic [3:0] code);
		case (code)
			PSC_DIV16:    psc_limit = PSC_TC_16;
			PSC_DIV256:   psc_limit = PSC_TC_256;
			PSC_DIV32768: psc_limit = PSC_TC_32768;
			default:      psc_limit = PSC_TC_1;
		endcase
	endfunction

	// One time field: {carry/borrow, next value}
	function automatic logic [8:0] field_step(input logic [7:0] val, input logic [7:0] lim,
		input logic up, input logic go);
		field_step = {1'b0, val};
		if (go) begin
			if (up) begin
				// Out-of-range values also roll, so a bad load cannot stick
				field_step = (val >= lim) ? {1'b1, 8'h00} : {1'b0, val + 8'h01};
			end else begin
				field_step = (val == 8'h00) ? {1'b1, lim} : {1'b0, val - 8'h01};
			end
		end
	endfunction

	// Next count with overflow flag: {overflow, next}
	function automatic logic [32:0] count_step(input logic [31:0] cur, input logic up,
		input logic [1:0] fmt);
		logic [7:0] hlim;
		logic [8:0] hu;
		logic [8:0] sc;
		logic [8:0] mn;
		logic [8:0] hr;
		hlim = (fmt == FMT_HMS255) ? HOURS_MAX_255 : HOURS_MAX_23;
		hu   = 9'h000;
		sc   = 9'h000;
		mn   = 9'h000;
		hr   = 9'h000;
		if (fmt == FMT_HMS23 || fmt == FMT_HMS255) begin
			// Hundredths carry into seconds, minutes, then hours
			hu = field_step(cur[7:0], HUND_MAX, up, 1'b1);
			sc = field_step(cur[15:8], MINSEC_MAX, up, hu[8]);
			mn = field_step(cur[23:16], MINSEC_MAX, up, sc[8]);
			hr = field_step(cur[31:24], hlim, up, mn[8]);
			count_step = {hr[8], hr[7:0], mn[7:0], sc[7:0], hu[7:0]};
		end else if (up) begin
			// Binary, and the reserved format, count plainly
			count_step = {&cur, cur + 32'h00000001};
		end else begin
			count_step = {cur == 32'h00000000, cur - 32'h00000001};
		end
	endfunction

	// Byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[8*i +: 8] = nw[8*i +: 8];
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus slave, prescaler, counter, interrupts
	always_comb begin
		logic        src_tick;     // Selected source edge
		logic        cnt_tick;     // Prescaled count enable
		logic        do_write;     // Write commits this cycle
		logic        clr_wr;       // Reload-and-clear write
		logic        ovf;          // Overflow this cycle
		logic [32:0] step;         // Step result
		logic [31:0] w1c;          // Status bits cleared by software
		logic [31:0] set_bits;     // Status bits set by hardware
		logic [31:0] wval;         // Merged write value
		logic [31:0] rd;           // Read data
		logic [1:0]  rresp;        // Read response
		logic        wr_err;       // Write to unmapped address
		src_tick = 1'b0;
		cnt_tick = 1'b0;
		do_write = 1'b0;
		clr_wr   = 1'b0;
		ovf      = 1'b0;
		step     = 33'h000000000;
		w1c      = 32'h00000000;
		set_bits = 32'h00000000;
		wval     = 32'h00000000;
		rd       = 32'h00000000;
		rresp    = RESP_OKAY;
		wr_err   = 1'b0;
		s_next   = s_reg;

		// Write address and data are taken independently
		if (axi_req_i.awvalid && s_reg.rsp.awready) begin
			s_next.aw_addr     = axi_req_i.awaddr;
			s_next.aw_got      = 1'b1;
			s_next.rsp.awready = 1'b0;
		end
		if (axi_req_i.wvalid && s_reg.rsp.wready) begin
			s_next.w_data     = axi_req_i.wdata;
			s_next.w_strb     = axi_req_i.wstrb;
			s_next.w_got      = 1'b1;
			s_next.rsp.wready = 1'b0;
		end

		// Commit once both halves are held
		if (s_reg.aw_got && s_reg.w_got && !s_reg.rsp.bvalid) begin
			do_write      = 1'b1;
			s_next.aw_got = 1'b0;
			s_next.w_got  = 1'b0;
		end

		// Register writes
		if (do_write) begin
			case (s_reg.aw_addr)
				ADDR_RELOAD_VALUE: begin
					s_next.reload = merge(s_reg.reload, s_reg.w_data, s_reg.w_strb);
				end
				ADDR_TIMER_CONFIG: begin
					wval            = merge(s_reg.config_r, s_reg.w_data, s_reg.w_strb);
					s_next.config_r = wval & CFG_WRITABLE;
				end
				ADDR_RELOAD_CLEAR: begin
					// Any data, any lanes
					clr_wr = 1'b1;
				end
				ADDR_IRQ_STATUS: begin
					w1c = s_reg.w_data & IRQ_WRITABLE;
				end
				ADDR_IRQ_ENABLE: begin
					wval          = merge(s_reg.enable, s_reg.w_data, s_reg.w_strb);
					s_next.enable = wval & IRQ_WRITABLE;
				end
				ADDR_CURRENT_COUNT, ADDR_CAPTURE: begin
					// Read-only: ignored, answered OKAY
				end
				default: begin
					wr_err = 1'b1;
				end
			endcase
			s_next.rsp.bvalid = 1'b1;
			s_next.rsp.bresp  = wr_err ? RESP_SLVERR : RESP_OKAY;
		end

		// Write response taken: reopen both channels
		if (s_reg.rsp.bvalid && axi_req_i.bready) begin
			s_next.rsp.bvalid  = 1'b0;
			s_next.rsp.awready = 1'b1;
			s_next.rsp.wready  = 1'b1;
		end

		// Source select; the core source ticks every sys_clk cycle
		case (wut_src_e'(s_reg.config_r[CFG_SRC_LSB +: 2]))
			SRC_OSC:  src_tick = osc_rise;
			SRC_CORE: src_tick = 1'b1;
			SRC_XTAL: src_tick = xtal_rise;
			SRC_PLL:  src_tick = pll_rise;
			default:  src_tick = 1'b0;
		endcase

		// Prescaler runs only while enabled
		if (s_reg.config_r[CFG_EN_BIT]) begin
			if (src_tick) begin
				if (s_reg.psc_cnt >= psc_limit(s_reg.config_r[CFG_PSC_LSB +: 4])) begin
					s_next.psc_cnt = 15'h0000;
					cnt_tick       = 1'b1;
				end else begin
					s_next.psc_cnt = s_reg.psc_cnt + 15'h0001;
				end
			end
		end else begin
			s_next.psc_cnt = 15'h0000;
		end

		// Counter step; nothing here depends on a core clock gate
		step = count_step(s_reg.count, s_reg.config_r[CFG_UP_BIT], s_reg.config_r[CFG_FMT_LSB +: 2]);
		if (cnt_tick) begin
			ovf          = step[32];
			s_next.count = step[31:0];
			if (ovf && s_reg.config_r[CFG_PER_BIT]) begin
				s_next.count = s_reg.reload;
			end
		end

		// Clear write reloads at once and restarts the prescaler
		if (clr_wr) begin
			s_next.count   = s_reg.reload;
			s_next.psc_cnt = 15'h0000;
		end

		// Overflow capture, gated by the timer interrupt enable
		if (ovf && s_reg.enable[IRQ_TIMER_BIT]) begin
			s_next.capture = s_reg.count;
		end

		// Sticky status: set beats clear in the same cycle
		set_bits[IRQ_TIMER_BIT] = ovf;
		if (clr_wr) begin
			w1c[IRQ_TIMER_BIT] = 1'b1;
		end
		s_next.status = ((s_reg.status & ~w1c) | set_bits) & IRQ_WRITABLE;
		s_next.irq    = |(s_next.status & s_next.enable);

		// Read port: data fetched when the address is taken
		if (axi_req_i.arvalid && s_reg.rsp.arready) begin
			case (axi_req_i.araddr)
				ADDR_RELOAD_VALUE:  rd = s_reg.reload;
				ADDR_CURRENT_COUNT: rd = s_reg.count;
				ADDR_TIMER_CONFIG:  rd = s_reg.config_r;
				ADDR_RELOAD_CLEAR:  rd = 32'h00000000;
				ADDR_IRQ_STATUS:    rd = s_reg.status;
				ADDR_IRQ_ENABLE:    rd = s_reg.enable;
				ADDR_CAPTURE:       rd = s_reg.capture;
				default:            rresp = RESP_SLVERR;
			endcase
			s_next.rsp.arready = 1'b0;
			s_next.rsp.rvalid  = 1'b1;
			s_next.rsp.rdata   = rd;
			s_next.rsp.rresp   = rresp;
		end

		// Read data taken: accept the next address
		if (s_reg.rsp.rvalid && axi_req_i.rready) begin
			s_next.rsp.rvalid  = 1'b0;
			s_next.rsp.arready = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs come straight from the state register
	assign axi_rsp_o = s_reg.rsp;
	assign irq_o     = s_reg.irq;

endmodule // wut_wakeup_counter

// ===== verif/wut_wakeup_counter_asserts.sv
`timescale 1ns/1ps
// Port-level watch on the register bus and the interrupt line
module wut_wakeup_counter_asserts
	import wut_pkg::*;
(
	// Clock and reset
	input wire logic                  sys_clk_i,
	input wire logic                  rst_n_i,
	// Register bus
	input wire wut_pkg::wut_axi_req_s axi_req_i,
	input wire wut_pkg::wut_axi_rsp_s axi_rsp_o,
	// Source pins and interrupt
	input wire logic                  osc32k_i,
	input wire logic                  xtal32k_i,
	input wire logic                  undivided_pll_clock_i,
	input wire logic                  irq_o
);
	logic [31:0] ar_addr_reg;  // Address of the read in flight
	logic        ar_bad;       // That address decodes to nothing

	// Remember the read address, the answer comes one edge later
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ar_addr_reg <= 32'h00000000;
		end else if (axi_req_i.arvalid && axi_rsp_o.arready) begin
			ar_addr_reg <= axi_req_i.araddr;
		end
	end
	assign ar_bad = !(ar_addr_reg inside {ADDR_RELOAD_VALUE, ADDR_CURRENT_COUNT, ADDR_TIMER_CONFIG,
		ADDR_RELOAD_CLEAR, ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_CAPTURE});

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////////////
	write_resp_hold_a: assert property (axi_rsp_o.bvalid && !axi_req_i.bready |=>
		axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp)) else $error("write response dropped early");
	read_resp_hold_a: assert property (axi_rsp_o.rvalid && !axi_req_i.rready |=>
		axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata)) else $error("read response dropped early");
	write_latency_a: assert property (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid &&
		axi_rsp_o.wready |=> !axi_rsp_o.bvalid ##1 axi_rsp_o.bvalid) else $error("write answer late");
	read_latency_a: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
		else $error("read answer late");
	write_busy_a: assert property (axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready)
		else $error("write accepted while busy");
	read_busy_a: assert property (axi_rsp_o.rvalid |-> !axi_rsp_o.arready)
		else $error("read accepted while busy");
	irq_fall_a: assert property ($fell(irq_o) |-> $rose(axi_rsp_o.bvalid))
		else $error("interrupt dropped without a write");
	clear_reads_zero_a: assert property ($rose(axi_rsp_o.rvalid) && ar_addr_reg == ADDR_RELOAD_CLEAR |->
		axi_rsp_o.rdata == 32'h00000000 && axi_rsp_o.rresp == RESP_OKAY) else $error("clear read not zero");
	unmapped_read_a: assert property ($rose(axi_rsp_o.rvalid) && ar_bad |->
		axi_rsp_o.rresp == RESP_SLVERR && axi_rsp_o.rdata == 32'h00000000) else $error("bad read not refused");
endmodule // wut_wakeup_counter_asserts

// ===== verif/wut_wakeup_counter_tb_top.sv
`timescale 1ns/1ps
module wut_wakeup_counter_tb_top;
	import wut_pkg::*;
	logic         sys_clk_i = 1'b0;
	logic         rst_n_i;
	wut_axi_req_s req       = '0;
	wut_axi_rsp_s rsp;
	logic         osc       = 1'b0;
	logic         xtal      = 1'b0;
	logic         pll       = 1'b0;
	logic         irq;
	int           n_errors  = 0;
	int           n_checks  = 0;
	int           cyc       = 0;
	int           k;
	int           i;
	logic [31:0]  seed      = 32'd15954;
	logic [31:0]  v;
	logic [33:0]  rq[$];    // Expected {rresp, rdata}
	logic [33:0]  bq[$];    // Expected bresp
	// Case table: config without enable, reload, count after stop, capture
	localparam logic [31:0] CF [10] = '{32'h244, 32'h204, 32'h304, 32'h228, 32'h000, 32'h400, 32'h640,
		32'h214, 32'h20F, 32'h338};
	localparam logic [31:0] RL [10] = '{32'h3, 32'h3, 32'hFFFFFFFE, 32'h0, 32'h1, 32'h1, 32'h1, 32'h2,
		32'h0, 32'hFF3B3B62};
	localparam logic [31:0] AF [10] = '{32'h3, 32'hFFFFFFFF, 32'h0, 32'h173B3B63, 32'hFFFFFFFF,
		32'hFFFFFFFF, 32'h1, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0};
	localparam logic [31:0] CP [10] = '{32'h0, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h0, 32'hFF3B3B63};

	wut_wakeup_counter u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .axi_req_i(req), .axi_rsp_o(rsp),
		.osc32k_i(osc), .xtal32k_i(xtal), .undivided_pll_clock_i(pll), .irq_o(irq));

	initial forever #50 sys_clk_i = ~sys_clk_i;

	// Slow source pins, each well under half the system rate
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 0) osc <= ~osc;
		if (cyc % 5 == 0) xtal <= ~xtal;
		if (cyc % 6 == 0) pll <= ~pll;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task summarize();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Answers are judged at their handshake edge, oldest note first
	always @(posedge sys_clk_i) begin
		if (rsp.rvalid && req.rready) cmp({rsp.rresp, rsp.rdata}, rq.pop_front());
		if (rsp.bvalid && req.bready) cmp({32'h0, rsp.bresp}, bq.pop_front());
	end

	// One write; an edge passes first so bready is never set twice in a step
	// A random late bready makes the slave hold its write response
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		int j;
		int w;
		bq.push_back({32'h0, r});
		w = rnd() % 3;
		@(posedge sys_clk_i);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		for (j = 0; j < 50; j++) begin
			@(posedge sys_clk_i);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid && req.bready) begin
				req.bready <= 1'b0;
				break;
			end
			if (j >= w) req.bready <= 1'b1;
		end
		if (j == 50) begin
			n_errors++;
			summarize();
		end
	endtask

	// A random late rready makes the slave hold its read data
	task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		int j;
		int w;
		rq.push_back({r, d});
		w = rnd() % 3;
		@(posedge sys_clk_i);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		for (j = 0; j < 50; j++) begin
			@(posedge sys_clk_i);
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid && req.rready) begin
				req.rready <= 1'b0;
				break;
			end
			if (j >= w) req.rready <= 1'b1;
		end
		if (j == 50) begin
			n_errors++;
			summarize();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n_i = 1'b0;
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		// Reset values, write-only and unmapped places
		rd(ADDR_RELOAD_VALUE, RST_RELOAD_VALUE, RESP_OKAY);
		rd(ADDR_CURRENT_COUNT, RST_CURRENT_COUNT, RESP_OKAY);
		rd(ADDR_TIMER_CONFIG, RST_TIMER_CONFIG, RESP_OKAY);
		rd(ADDR_IRQ_STATUS, RST_IRQ_STATUS, RESP_OKAY);
		rd(ADDR_IRQ_ENABLE, RST_IRQ_ENABLE, RESP_OKAY);
		rd(ADDR_CAPTURE, RST_CAPTURE, RESP_OKAY);
		rd(ADDR_RELOAD_CLEAR, 32'h0, RESP_OKAY);
		rd(32'hFFFF035C, 32'h0, RESP_SLVERR);
		wr(32'hFFFF035C, rnd(), RESP_SLVERR);
		// Read-write and read-only access
		v = rnd();
		wr(ADDR_RELOAD_VALUE, v, RESP_OKAY);
		rd(ADDR_RELOAD_VALUE, v, RESP_OKAY);
		v = rnd() & 32'hFFFFFF7F;  // Keep the timer stopped here
		wr(ADDR_TIMER_CONFIG, v, RESP_OKAY);
		rd(ADDR_TIMER_CONFIG, v & CFG_WRITABLE, RESP_OKAY);
		wr(ADDR_CURRENT_COUNT, rnd(), RESP_OKAY);
		rd(ADDR_CURRENT_COUNT, 32'h0, RESP_OKAY);
		wr(ADDR_IRQ_ENABLE, 32'hFFFFFFFF, RESP_OKAY);
		rd(ADDR_IRQ_ENABLE, IRQ_WRITABLE, RESP_OKAY);
		// Every source, direction, mode and format up to one overflow
		for (k = 0; k < 10; k++) begin
			wr(ADDR_RELOAD_VALUE, RL[k], RESP_OKAY);
			wr(ADDR_TIMER_CONFIG, CF[k], RESP_OKAY);
			wr(ADDR_RELOAD_CLEAR, rnd(), RESP_OKAY);
			rd(ADDR_CURRENT_COUNT, RL[k], RESP_OKAY);
			cmp({33'h0, irq}, 34'h0);
			wr(ADDR_TIMER_CONFIG, CF[k] | 32'h80, RESP_OKAY);
			for (i = 0; i < 40000 && irq !== 1'b1; i++) @(posedge sys_clk_i);
			if (i == 40000) begin
				n_errors++;
				summarize();
			end
			wr(ADDR_TIMER_CONFIG, CF[k], RESP_OKAY);
			rd(ADDR_CURRENT_COUNT, AF[k], RESP_OKAY);
			rd(ADDR_CAPTURE, CP[k], RESP_OKAY);
			rd(ADDR_IRQ_STATUS, 32'h10, RESP_OKAY);
			wr(ADDR_RELOAD_CLEAR, rnd(), RESP_OKAY);
			cmp({33'h0, irq}, 34'h0);
			rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
			rd(ADDR_CURRENT_COUNT, RL[k], RESP_OKAY);
		end
		// Masked overflow: no interrupt and no capture
		wr(ADDR_IRQ_ENABLE, 32'h0, RESP_OKAY);
		wr(ADDR_RELOAD_VALUE, 32'h2, RESP_OKAY);
		wr(ADDR_RELOAD_CLEAR, rnd(), RESP_OKAY);
		wr(ADDR_TIMER_CONFIG, 32'h280, RESP_OKAY);
		wr(ADDR_TIMER_CONFIG, 32'h200, RESP_OKAY);
		rd(ADDR_IRQ_STATUS, 32'h10, RESP_OKAY);
		cmp({33'h0, irq}, 34'h0);
		rd(ADDR_CAPTURE, CP[9], RESP_OKAY);
		wr(ADDR_IRQ_ENABLE, 32'h10, RESP_OKAY);
		cmp({33'h0, irq}, 34'h1);
		wr(ADDR_IRQ_STATUS, 32'h10, RESP_OKAY);
		cmp({33'h0, irq}, 34'h0);
		rd(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
		summarize();
	end
endmodule // wut_wakeup_counter_tb_top

bind wut_wakeup_counter wut_wakeup_counter_asserts u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .osc32k_i(osc32k_i), .xtal32k_i(xtal32k_i),
	.undivided_pll_clock_i(undivided_pll_clock_i), .irq_o(irq_o));
